// [src/ebic_core.sv]
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
module ebic_core
    import ebic_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_RSTN,
    input wire logic [31:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    input wire logic [1:0] I_EXP_LEVEL,
    input wire logic [3:0] I_EXP_IRQ,
    input wire logic [1:0] I_LOCAL_IRQ,
    input wire logic I_EXP_ERROR,
    input wire logic I_EXP_READY,
    input wire logic [7:0] I_ACK_DATA,
    output logic O_ACK_STROBE_N,
    output logic O_ACK_LEVEL,
    output logic O_VEC_VALID,
    output logic [7:0] O_VEC,
    output logic O_VEC_LEVEL,
    output logic [6:0] O_GATED_IRQ,
    output logic O_IRQ
);
    typedef enum logic [2:0] {ST_IDLE, ST_ACT, ST_STRETCH, ST_REC, ST_WAIT_DONE} ebic_state_t;

    logic [15:0] setup;
    logic [6:0] gate;
    logic [6:0] gated;
    logic [1:0] evt_status;
    logic [1:0] evt_mask;
    logic [7:0] vec_hold [2];
    ebic_state_t state;
    ebic_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic cur;
    logic second;
    logic [1:0] busy;

    function automatic logic [CNT_W-1:0] width_cycles(input logic [2:0] code);
        width_cycles = CNT_W'(BASE_CYC + STEP_CYC * int'(code) - 1);
    endfunction

    function automatic logic [7:0] pick_vector(input logic lvl, input logic [7:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        lo = lvl ? VEC1_LOW : VEC0_LOW;
        hi = lvl ? VEC1_HIGH : VEC0_HIGH;
        pick_vector = (v >= lo && v <= hi) ? v : hi;
    endfunction

    wire wr_setup = I_WR && I_ADDR == SETUP_ADDR;
    wire wr_gate = I_WR && I_ADDR == GATE_ADDR;
    wire wr_done0 = I_WR && I_ADDR == DONE0_ADDR;
    wire wr_done1 = I_WR && I_ADDR == DONE1_ADDR;
    wire wr_status = I_WR && I_ADDR == EVT_STATUS_ADDR;
    wire wr_mask = I_WR && I_ADDR == EVT_MASK_ADDR;
    wire [7:0] field0 = setup[7:0];
    wire [7:0] field1 = setup[15:8];
    wire [7:0] cur_field = cur ? field1 : field0;
    wire [6:0] raw_in = {I_EXP_ERROR, I_LOCAL_IRQ, I_EXP_IRQ};
    // Gate applied to the raw input ahead of the register: mask and input are combined, then sampled on one edge
    wire [6:0] next_gated = raw_in & gate;
    wire [1:0] req = I_EXP_LEVEL & gated[1:0] & ~busy;
    wire start = state == ST_IDLE && req != 2'b00;
    wire start_lvl = ~req[0];
    wire [7:0] start_field = start_lvl ? field1 : field0;
    wire direct = start && !start_field[F_ACK_EN];
    // Sample only where the state machine leaves the pulse, never mid-step
    wire done_ack = (state == ST_STRETCH || state == ST_ACT) && cnt == '0 && I_EXP_READY;
    wire last_rec = state == ST_REC && cnt == '0;
    wire finish = last_rec && (second || !cur_field[F_TWO_PULSE]);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        unique case (state)
            ST_IDLE: begin
                if (start && start_field[F_ACK_EN]) begin
                    next_state = ST_ACT;
                    next_cnt = width_cycles(start_field[F_ACT_LSB +: 3]);
                end
            end
            ST_ACT: begin
                if (cnt != '0) begin
                    next_cnt = cnt - 1'b1;
                end else if (I_EXP_READY) begin
                    next_state = ST_REC;
                    next_cnt = width_cycles(cur_field[F_REC_LSB +: 3]);
                end else begin
                    next_state = ST_STRETCH;
                    next_cnt = CNT_W'(STRETCH_CYC - 1);
                end
            end
            ST_STRETCH: begin
                // Stretch only in whole 40 ns steps
                if (cnt != '0) begin
                    next_cnt = cnt - 1'b1;
                end else if (I_EXP_READY) begin
                    next_state = ST_REC;
                    next_cnt = width_cycles(cur_field[F_REC_LSB +: 3]);
                end else begin
                    next_cnt = CNT_W'(STRETCH_CYC - 1);
                end
            end
            ST_REC: begin
                if (cnt != '0) begin
                    next_cnt = cnt - 1'b1;
                end else if (finish) begin
                    next_state = ST_WAIT_DONE;
                end else begin
                    next_state = ST_ACT;
                    next_cnt = width_cycles(cur_field[F_ACT_LSB +: 3]);
                end
            end
            ST_WAIT_DONE: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state <= ST_IDLE;
            cnt <= '0;
            cur <= 1'b0;
            second <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            if (start) cur <= start_lvl;
            if (start) second <= 1'b0;
            else if (last_rec) second <= 1'b1;
        end
    end

    // Latched sample of the returned vector on the strobe's rising edge; a direct start loads its level's low vector instead
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_VEC_VALID <= 1'b0;
            O_VEC <= '0;
            O_VEC_LEVEL <= 1'b0;
        end else begin
            O_VEC_VALID <= direct || (done_ack && (second || !cur_field[F_TWO_PULSE]));
            if (direct) begin
                O_VEC <= start_lvl ? VEC1_LOW : VEC0_LOW;
                O_VEC_LEVEL <= start_lvl;
            end else if (done_ack) begin
                O_VEC <= pick_vector(cur, I_ACK_DATA);
                O_VEC_LEVEL <= cur;
            end
        end
    end

    // Level stays busy until its done command, so one acknowledge per interrupt
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            busy <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (start && start_field[F_ACK_EN] && start_lvl == 1'(i)) busy[i] <= 1'b1;
                else if (i == 0 ? wr_done0 : wr_done1) busy[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            setup <= SETUP_RESET;
            gate <= GATE_RESET;
            gated <= '0;
            evt_mask <= '0;
            evt_status <= '0;
        end else begin
            if (wr_setup) setup <= I_WDATA[15:0];
            if (wr_gate) gate <= I_WDATA[6:0];
            gated <= next_gated;
            if (wr_mask) evt_mask <= I_WDATA[1:0];
            // Set wins over write-one-to-clear
            evt_status <= (evt_status & ~(wr_status ? I_WDATA[1:0] : 2'b00))
                | {1'b0, O_VEC_VALID} | {wr_done0 | wr_done1, 1'b0};
        end
    end

    assign vec_hold[0] = O_VEC_LEVEL ? 8'h00 : O_VEC;
    assign vec_hold[1] = O_VEC_LEVEL ? O_VEC : 8'h00;

    wire [31:0] rd_mux =
        I_ADDR == SETUP_ADDR ? {16'h0000, setup} :
        I_ADDR == GATE_ADDR ? {25'h0000000, gate} :
        I_ADDR == EVT_STATUS_ADDR ? {30'h00000000, evt_status} :
        I_ADDR == EVT_MASK_ADDR ? {30'h00000000, evt_mask} :
        I_ADDR == VEC0_ADDR ? {24'h000000, vec_hold[0]} :
        I_ADDR == VEC1_ADDR ? {24'h000000, vec_hold[1]} : 32'h00000000;

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) O_RDATA <= '0;
        else O_RDATA <= I_RD ? rd_mux : 32'h00000000;
    end

    assign O_ACK_STROBE_N = !(state == ST_ACT || state == ST_STRETCH);
    assign O_ACK_LEVEL = cur;
    assign O_GATED_IRQ = gated;
    assign O_IRQ = |(evt_status & evt_mask);
endmodule

// [src/ebic_pkg.sv]
package ebic_pkg;
    localparam int ADDR_W = 32;
    localparam logic [31:0] SETUP_ADDR = 32'h1FF88010;
    localparam logic [31:0] GATE_ADDR = 32'h1FF88014;
    localparam logic [31:0] DONE0_ADDR = 32'h1FF89000;
    localparam logic [31:0] DONE1_ADDR = 32'h1FF8A000;
    localparam logic [31:0] EVT_STATUS_ADDR = 32'h1FF88020;
    localparam logic [31:0] EVT_MASK_ADDR = 32'h1FF88024;
    localparam logic [31:0] VEC0_ADDR = 32'h1FF88028;
    localparam logic [31:0] VEC1_ADDR = 32'h1FF8802C;
    localparam logic [15:0] SETUP_RESET = 16'h0000;
    localparam logic [6:0] GATE_RESET = 7'h00;
    localparam int F_ACK_EN = 0;
    localparam int F_TWO_PULSE = 1;
    localparam int F_ACT_LSB = 2;
    localparam int F_REC_LSB = 5;
    localparam int GATE_ERR = 6;
    localparam int GATE_LOC_LSB = 4;
    localparam int GATE_EXP_LSB = 0;
    localparam logic [7:0] VEC0_LOW = 8'hA8;
    localparam logic [7:0] VEC0_HIGH = 8'hCF;
    localparam logic [7:0] VEC1_LOW = 8'h80;
    localparam logic [7:0] VEC1_HIGH = 8'hA7;
    localparam int CLK_NS = 20;
    localparam int WIDTH_BASE_NS = 120;
    localparam int WIDTH_STEP_NS = 80;
    localparam int STRETCH_NS = 40;
    localparam int BASE_CYC = (WIDTH_BASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int STEP_CYC = (WIDTH_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STRETCH_CYC = (STRETCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 6;
endpackage

// [verif/ebic_core_monitor.sv]
`timescale 1ns/100ps
module ebic_core_mon
    import ebic_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_RSTN,
    input wire logic [3:0] I_EXP_IRQ,
    input wire logic [1:0] I_LOCAL_IRQ,
    input wire logic I_EXP_ERROR,
    input wire logic I_EXP_READY,
    input wire logic O_ACK_STROBE_N,
    input wire logic O_ACK_LEVEL,
    input wire logic O_VEC_VALID,
    input wire logic [7:0] O_VEC,
    input wire logic O_VEC_LEVEL,
    input wire logic [6:0] O_GATED_IRQ
);
    wire logic [6:0] raw_in = {I_EXP_ERROR, I_LOCAL_IRQ, I_EXP_IRQ};
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RSTN);
    a_gate_quiet: assert property (
        raw_in == 7'h00 |=> O_GATED_IRQ == 7'h00) else $error("gated without input");
    a_gate_in_step: assert property (
        (O_GATED_IRQ & ~$past(raw_in)) == 7'h00) else $error("gated ahead of input");
    a_ack_low_min: assert property (
        $fell(O_ACK_STROBE_N) |-> !O_ACK_STROBE_N [*6]) else $error("strobe too short");
    a_ack_rec_min: assert property (
        $rose(O_ACK_STROBE_N) |-> O_ACK_STROBE_N [*6]) else $error("recovery too short");
    a_ready_stretch: assert property (
        !O_ACK_STROBE_N && !I_EXP_READY |=> !O_ACK_STROBE_N) else $error("no stretch");
    a_level_steady: assert property (
        !O_ACK_STROBE_N ##1 !O_ACK_STROBE_N |-> $stable(O_ACK_LEVEL)) else $error("level moved");
    a_vec0_range: assert property (
        O_VEC_VALID && !O_VEC_LEVEL |-> O_VEC inside {[VEC0_LOW:VEC0_HIGH]}) else $error("vec0 range");
    a_vec1_range: assert property (
        O_VEC_VALID && O_VEC_LEVEL |-> O_VEC inside {[VEC1_LOW:VEC1_HIGH]}) else $error("vec1 range");
    c_level1_vec: cover property (O_VEC_VALID && O_VEC_LEVEL);
    c_stretched: cover property (!O_ACK_STROBE_N && !I_EXP_READY);
    c_direct0: cover property (O_VEC_VALID && O_VEC == VEC0_LOW);
endmodule
bind ebic_core ebic_core_mon u_mon (.*);

// [verif/ebic_periph.sv]
`timescale 1ns/100ps
module ebic_periph (
    input wire logic i_clock,
    input wire logic i_strobe_n,
    input wire logic [7:0] i_vector,
    input wire logic [3:0] i_hold,
    output logic o_ready,
    output logic [7:0] o_data
);
    logic [3:0] held = 4'h0;
    logic [7:0] churn = 8'h3C;
    always_ff @(posedge i_clock) begin
        held <= i_strobe_n ? 4'h0 : held + {3'h0, held != 4'hF};
        churn <= churn + 8'h5B;
    end
    // Not ready for the first i_hold cycles of each pulse
    assign o_ready = i_strobe_n || held >= i_hold;
    // Released lines churn so a late sample never matches by luck
    assign o_data = i_strobe_n ? churn : i_vector;
endmodule

// [verif/tb.sv]
`timescale 1ns/100ps
module tb
    import ebic_pkg::*;
;
    logic I_CLOCK = 1'b0, I_RSTN = 1'b0, I_WR = 1'b0, I_RD = 1'b0, I_EXP_ERROR = 1'b0;
    logic [31:0] I_ADDR = 32'h0, I_WDATA = 32'h0, O_RDATA;
    logic [1:0] I_EXP_LEVEL = 2'b00, I_LOCAL_IRQ = 2'b00;
    logic [3:0] I_EXP_IRQ = 4'h0, ph = 4'h0;
    logic [7:0] I_ACK_DATA, O_VEC, pv = 8'h00, lo;
    logic [6:0] O_GATED_IRQ, g;
    logic I_EXP_READY, O_ACK_STROBE_N, O_ACK_LEVEL, O_VEC_VALID, O_VEC_LEVEL, O_IRQ, rd_p = 1'b0;
    logic cur_lvl = 1'b0;
    logic [31:0] exp_rd[$];
    logic [8:0] exp_vec[$];
    int fail_count = 0, compares = 0, seed = 33028, low_len = 0, w;
    int lens[$];
    ebic_core dut (.*);
    ebic_periph u_periph (.i_clock(I_CLOCK), .i_strobe_n(O_ACK_STROBE_N), .i_vector(pv),
        .i_hold(ph), .o_ready(I_EXP_READY), .o_data(I_ACK_DATA));
    always #10 I_CLOCK = ~I_CLOCK;
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic bus(input logic we, input logic re, input logic [31:0] a, input logic [31:0] d);
        I_WR <= we;
        I_RD <= re;
        I_ADDR <= a;
        I_WDATA <= d;
        @(posedge I_CLOCK);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, 1'b0, a, d);
        bus(1'b0, 1'b0, a, d);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        bus(1'b0, 1'b1, a, $random(seed));
        bus(1'b0, 1'b0, a, 32'h0);
    endtask
    task automatic irq_is(input logic e);
        @(negedge I_CLOCK);
        chk("irq", {31'h0, e}, {31'h0, O_IRQ});
        @(posedge I_CLOCK);
    endtask
    task automatic req(input logic lvl, input logic [8:0] e, input logic want);
        if (want) exp_vec.push_back(e);
        cur_lvl = lvl;
        I_EXP_LEVEL <= lvl ? 2'b10 : 2'b01;
        @(posedge I_CLOCK);
        I_EXP_LEVEL <= 2'b00;
        for (int i = 0; i < 400 && exp_vec.size() > 0; i++) @(posedge I_CLOCK);
        repeat (80) @(posedge I_CLOCK);
        chk("vectors left", 32'h0, exp_vec.size());
    endtask
    always @(posedge I_CLOCK) begin
        if (rd_p) chk("read", exp_rd.size() ? exp_rd.pop_front() : 32'hX, O_RDATA);
        rd_p = I_RD;
        if (O_VEC_VALID) chk("vector", exp_vec.size() ? {23'h0, exp_vec.pop_front()} : 32'hX,
            {23'h0, O_VEC_LEVEL, O_VEC});
        if (!O_ACK_STROBE_N) chk("ack level", {31'h0, cur_lvl}, {31'h0, O_ACK_LEVEL});
        if (!O_ACK_STROBE_N) low_len++;
        else if (low_len > 0) begin
            lens.push_back(low_len);
            low_len = 0;
        end
    end
    initial begin
        repeat (5) @(posedge I_CLOCK);
        I_RSTN <= 1'b1;
        @(posedge I_CLOCK);
        rd(SETUP_ADDR, 32'h0);
        rd(GATE_ADDR, 32'h0);
        rd(32'h1FF88030, 32'h0);
        for (int i = 0; i < 8; i++) begin
            g = 7'($random(seed));
            wr(GATE_ADDR, {25'h0, g});
            {I_EXP_ERROR, I_LOCAL_IRQ, I_EXP_IRQ} <= 7'($random(seed));
            repeat (2) @(negedge I_CLOCK);
            chk("gated", {25'h0, g & {I_EXP_ERROR, I_LOCAL_IRQ, I_EXP_IRQ}}, {25'h0, O_GATED_IRQ});
            @(posedge I_CLOCK);
            rd(GATE_ADDR, {25'h0, g});
        end
        {I_EXP_ERROR, I_LOCAL_IRQ, I_EXP_IRQ} <= 7'h03;
        wr(GATE_ADDR, 32'h3);
        wr(EVT_MASK_ADDR, 32'h0);
        wr(SETUP_ADDR, 32'h0100);
        req(1'b0, {1'b0, VEC0_LOW}, 1'b1);
        irq_is(1'b0);
        wr(EVT_MASK_ADDR, 32'h1);
        irq_is(1'b1);
        wr(EVT_STATUS_ADDR, 32'h1);
        irq_is(1'b0);
        wr(SETUP_ADDR, 32'h0);
        req(1'b1, {1'b1, VEC1_LOW}, 1'b1);
        for (int m = 0; m < 8; m++) begin
            w = $random(seed);
            wr(SETUP_ADDR, {16'h0, {2{w[6:4], w[3:1], w[0], 1'b1}}});
            lo = m[0] ? VEC1_LOW : VEC0_LOW;
            pv = m[1] ? 8'h10 : lo + 8'($unsigned($random(seed)) % 40);
            ph = m[2] ? 4'hC : 4'h0;
            lens.delete();
            req(m[0], {m[0], m[1] ? (m[0] ? VEC1_HIGH : VEC0_HIGH) : pv}, 1'b1);
            chk("pulse count", {31'h0, w[0]} + 32'h1, lens.size());
            foreach (lens[j]) chk("width", ph ? 1 : 6 + 4 * w[3:1], ph ? lens[j] >= 12 : lens[j]);
            req(m[0], 9'h0, 1'b0);
            wr(m[0] ? DONE1_ADDR : DONE0_ADDR, $random(seed));
        end
        wrap_up();
    end
    initial begin
        #600000;
        fail_count++;
        wrap_up();
    end
endmodule
